// ---- testbench/acsi_host_model.sv ----
// Host controller model: drives convert, serial clock and config pins.
// Assumes tasks are called just after a core clock edge; SCK is 200 ns.
`timescale 1ns/100ps
module acsi_host_model
(
	input  wire logic core_clk_i,
	input  wire logic result_i,
	output logic      start_o,
	output logic      sck_o,
	output logic      cfg_o
);
	initial
	begin
		start_o = 1'b0;
		sck_o   = 1'b0;
		cfg_o   = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : wait_clk

	// Levels change together, then settle past the synchroniser
	task automatic set_pins(input logic st, input logic cf, input int n);
		start_o <= st;
		cfg_o   <= cf;
		wait_clk(n);
	endtask : set_pins

	// Clears the busy bit; moves no data
	task automatic pulse;
		sck_o <= 1'b1;
		wait_clk(4);
		sck_o <= 1'b0;
		wait_clk(4);
	endtask : pulse

	// Data set up a half period before the rise, result sampled mid high
	task automatic frame(input int n, input logic [15:0] din, output logic [31:0] q);
		q = '0;
		for (int i = 0; i < n; i++)
		begin
			cfg_o <= (i < 16) ? din[15 - i] : 1'b1;
			wait_clk(4);
			sck_o <= 1'b1;
			wait_clk(2);
			q = {q[30:0], result_i};
			wait_clk(2);
			sck_o <= 1'b0;
		end
		wait_clk(4);
	endtask : frame
endmodule : acsi_host_model

// ---- testbench/adc_serial_mode_interface_bench.sv ----
// Self-checking bench: APB register access and a host model on the pins.
// Assumes a 40 MHz core clock; the released result pin floats.
`timescale 1ns/100ps
module adc_serial_mode_interface_bench;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [15:0] sample = 16'h0000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        perr;
	logic        res_out;
	logic        oe;
	logic        irq;
	logic        start_pin;
	logic        sck;
	logic        cfg_pin;
	logic [31:0] q;
	wire         res_line;
	int          miscompares = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #12.5 clk = ~clk;

	// Undriven pin reads z, so a missing enable fails the compare
	assign res_line = oe ? res_out : 1'bz;

	acsi_core uut (.core_clk_i(clk), .resetn_i(resetn), .convert_start_i(start_pin), .shift_clk_i(sck),
		.serial_config_chain_in_i(cfg_pin), .sample_i(sample), .serial_result_out_o(res_out),
		.serial_result_oe_o(oe), .irq_o(irq), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

	acsi_host_model host (.core_clk_i(clk), .result_i(res_line), .start_o(start_pin), .sck_o(sck),
		.cfg_o(cfg_pin));

	task automatic wrap_up;
		$display("Checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	// One idle cycle after release keeps psel from being set twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits as long as the slave needs; only the cycle ceiling ends a hung wait
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk(nm, e, r);
	endtask : rd

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(acsi_pkg::OFS_CTRL, 32'h0000_0001, "ctrl");
		rd(acsi_pkg::OFS_STATUS, 32'h0000_0000, "status");
		rd(acsi_pkg::OFS_MASK, 32'h0000_0000, "mask");
		apb(1'b0, 8'h40, 32'h0000_0000, q);
		chk("unmapped err", 32'h0000_0001, 32'(perr));
		chk("unmapped data", 32'h0000_0000, q);
		wr(acsi_pkg::OFS_MASK, 32'h0000_0007);
		sample <= 16'hA5C3;
		host.set_pins(1'b1, 1'b1, 4);
		host.set_pins(1'b0, 1'b1, 36);
		chk("busy bit", 32'h0000_0001, 32'(res_line));
		chk("irq set", 32'h0000_0001, 32'(irq));
		host.pulse();
		host.frame(16, 16'hFFFF, q);
		chk("select data", 32'h0000_A5C3, q);
		rd(acsi_pkg::OFS_RESULT, 32'h0000_A5C3, "result");
		rd(acsi_pkg::OFS_STATUS, 32'h0000_0005, "status events");
		wr(acsi_pkg::OFS_MASK, 32'h0000_0000);
		// Interrupt is registered, so it drops one cycle after the mask lands
		@(posedge clk);
		chk("irq masked", 32'h0000_0000, 32'(irq));
		wr(acsi_pkg::OFS_STATUS, 32'h0000_0007);
		rd(acsi_pkg::OFS_STATUS, 32'h0000_0000, "status clear");
		host.set_pins(1'b1, 1'b1, 40);
		chk("oe off", 32'h0000_0000, 32'(oe));
		host.set_pins(1'b1, 1'b0, 8);
		chk("oe by sdi", 32'h0000_0001, 32'(oe));
		host.set_pins(1'b1, 1'b1, 8);
		chk("oe off again", 32'h0000_0000, 32'(oe));
		host.set_pins(1'b0, 1'b1, 8);
		chk("oe by cnv", 32'h0000_0001, 32'(oe));
		sample <= 16'h3C96;
		host.set_pins(1'b1, 1'b0, 40);
		chk("chain oe", 32'h0000_0001, 32'(oe));
		rd(acsi_pkg::OFS_STATE, 32'h0000_0007, "chain state");
		host.frame(32, 16'hB1E4, q);
		chk("chain data", 32'h3C96_B1E4, q);
		host.set_pins(1'b0, 1'b1, 8);
		wr(acsi_pkg::OFS_STATUS, 32'h0000_0007);
		wr(acsi_pkg::OFS_CTRL, 32'h0000_0003);
		host.frame(16, 16'h5A3C, q);
		host.set_pins(1'b0, 1'b1, 8);
		rd(acsi_pkg::OFS_CFG, 32'h0000_5A3C, "config word");
		rd(acsi_pkg::OFS_STATUS, 32'h0000_0002, "config event");
		// Conversions disabled: a convert edge must leave state and events alone
		wr(acsi_pkg::OFS_CTRL, 32'h0000_0000);
		host.set_pins(1'b1, 1'b1, 40);
		rd(acsi_pkg::OFS_STATE, 32'h0000_0007, "state no conv");
		rd(acsi_pkg::OFS_STATUS, 32'h0000_0002, "status no conv");
		wrap_up();
	end
endmodule : adc_serial_mode_interface_bench

// ---- verilog/acsi_conv_timer.sv ----
// Conversion timer running from the core clock, standing in for the internal oscillator.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/100ps
module acsi_conv_timer
(
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);
	logic [7:0] cnt;

	// No serial clock needed while converting
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt    <= 8'h00;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= busy_o && (cnt == 8'h00);
			if (start_i && !busy_o)
			begin
				cnt    <= 8'(acsi_pkg::CONV_CYCLES - 1);
				busy_o <= 1'b1;
			end
			else if (busy_o)
			begin
				if (cnt == 8'h00)
					busy_o <= 1'b0;
				else
					cnt <= cnt - 8'h01;
			end
		end
	end

	conv_len_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(start_i && !busy_o) |-> ##21 done_o)
		else $error("Conversion did not finish after 20 cycles");
endmodule : acsi_conv_timer

// ---- verilog/acsi_core.sv ----
// Serial interface of a 16-bit converter: mode latch, readout, chain and config write.
// Assumes pins arrive asynchronously, sample data comes from the core clock domain,
// and software reaches the registers over APB.
//
// How it works
// - Convert-start rising edge begins a conversion and latches the interface mode.
// - Select-gated mode drives the result output only while convert-start or config input is low.
// - Chain mode shifts result data while convert-start is high; host reads then.
// - Result output is shifted in step with the host serial clock.
// - Each serial clock cycle while selected and the busy indicator is clear shifts out the next result bit.
// - Config/chain input low at convert-start rise selects chain mode.
// - In chain mode the config/chain input feeds the shift chain.
// - In chain mode the input level reaches the output after 16 clock cycles.
// - Config/chain input high at convert-start rise selects select-gated mode.
// - Once a conversion has started, select-gated mode enables output while convert-start or config input is low.
// - In select-gated mode, either input low at conversion end enables the busy indicator.
// - With convert-start low, 16 config bits are sampled on serial clock rises.
// - Conversion runs from an internal clock, no serial clock needed.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module acsi_core
(
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        convert_start_i,
	input  wire logic        shift_clk_i,
	input  wire logic        serial_config_chain_in_i,
	input  wire logic [15:0] sample_i,
	output logic             serial_result_out_o,
	output logic             serial_result_oe_o,
	output logic             irq_o,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	typedef enum logic [1:0] {
		ACSI_IDLE = 2'b00,
		ACSI_CONV = 2'b01,
		ACSI_READ = 2'b11
	} acsi_state_t;

	acsi_pkg::acsi_pins_t pins;
	acsi_state_t          state;
	logic                 start_q;
	logic                 sck_q;
	logic                 mode_chain;
	logic                 busy_ind;
	logic                 chain_cap;
	logic [15:0]          shreg;
	logic [4:0]           bit_cnt;
	logic [15:0]          cfg_shift;
	logic [4:0]           cfg_cnt;
	logic [15:0]          cfg_word;
	logic [15:0]          result;
	logic [1:0]           ctrl;
	logic [2:0]           status;
	logic [2:0]           mask;
	logic                 conv_busy;
	logic                 conv_done;

	acsi_sync #(.W(3)) u_sync
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.async_i    ({convert_start_i, shift_clk_i, serial_config_chain_in_i}),
		.sync_o     (pins)
	);

	wire start_rise = pins.start && !start_q;
	wire sck_rise   = pins.sck && !sck_q;
	wire sck_fall   = !pins.sck && sck_q;
	wire conv_go    = start_rise && ctrl[acsi_pkg::CTRL_EN_BIT] && !conv_busy;

	acsi_conv_timer u_timer
	(
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.start_i    (conv_go),
		.busy_o     (conv_busy),
		.done_o     (conv_done)
	);

	// Enable terms per mode; reading and writing share the chain's timing
	wire cs_enable    = !mode_chain && (!pins.start || !pins.cfg_in);
	wire chain_enable = mode_chain && pins.start;
	wire selected     = (state == ACSI_READ) && (cs_enable || chain_enable);
	wire next_oe      = (state != ACSI_IDLE) && (cs_enable || chain_enable) &&
	                    !(mode_chain && state == ACSI_CONV);
	wire next_out     = next_oe && (busy_ind || (state == ACSI_READ && shreg[15]));
	wire shift_now    = selected && sck_fall && !busy_ind;
	wire read_last    = shift_now && (bit_cnt == 5'(acsi_pkg::WORD_BITS - 1));
	wire cfg_take     = ctrl[acsi_pkg::CTRL_CFG_BIT] && !pins.start && sck_rise && !conv_busy;
	wire cfg_last     = cfg_take && (cfg_cnt == 5'(acsi_pkg::WORD_BITS - 1));

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			start_q <= 1'b0;
			sck_q <= 1'b0;
		end
		else
		begin
			start_q <= pins.start;
			sck_q <= pins.sck;
		end
	end

	// Mode is caught at the convert edge and kept until the next one
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mode_chain <= 1'b0;
		else if (conv_go)
			mode_chain <= !pins.cfg_in;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state <= ACSI_IDLE;
		else
		begin
			unique case (state)
				ACSI_IDLE: if (conv_go) state <= ACSI_CONV;
				ACSI_CONV: if (conv_done) state <= ACSI_READ;
				ACSI_READ: if (conv_go) state <= ACSI_CONV;
				// Unused code 2'b10 falls back to idle
				default:   state <= ACSI_IDLE;
			endcase
		end
	end

	// Busy indicator: high at completion in select-gated mode with either pin low, cleared by the first falling serial edge
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			busy_ind <= 1'b0;
		else if (conv_done)
			busy_ind <= !mode_chain && (!pins.start || !pins.cfg_in);
		else if (sck_fall || conv_go)
			busy_ind <= 1'b0;
	end

	// Chain input sampled on the rise, moved in on the fall: 16 full cycles of delay
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			chain_cap <= 1'b0;
		else if (sck_rise)
			chain_cap <= pins.cfg_in;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			shreg   <= acsi_pkg::WORD_RESET;
			result  <= acsi_pkg::WORD_RESET;
			bit_cnt <= 5'h00;
		end
		else if (conv_done)
		begin
			shreg   <= sample_i;
			result  <= sample_i;
			bit_cnt <= 5'h00;
		end
		else if (shift_now)
		begin
			shreg   <= {shreg[14:0], mode_chain && chain_cap};
			bit_cnt <= read_last ? 5'h00 : bit_cnt + 5'h01;
		end
	end

	// Config word: a convert-start high aborts a partial word
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cfg_shift <= acsi_pkg::WORD_RESET;
			cfg_cnt   <= 5'h00;
			cfg_word  <= acsi_pkg::WORD_RESET;
		end
		else if (pins.start)
			cfg_cnt <= 5'h00;
		else if (cfg_take)
		begin
			cfg_shift <= {cfg_shift[14:0], pins.cfg_in};
			cfg_cnt   <= cfg_last ? 5'h00 : cfg_cnt + 5'h01;
			if (cfg_last)
				cfg_word <= {cfg_shift[14:0], pins.cfg_in};
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			serial_result_oe_o  <= 1'b0;
			serial_result_out_o <= 1'b0;
		end
		else
		begin
			serial_result_oe_o  <= next_oe;
			serial_result_out_o <= next_out;
		end
	end

	// Register bus: one wait state, so every answer comes from a flop
	wire        acc      = psel_i && penable_i && !pready_o;
	// Writes land on the completion edge, where the master sees pready high
	wire        acc_end  = psel_i && penable_i && pready_o;
	wire        hit_ctrl = paddr_i == acsi_pkg::OFS_CTRL;
	wire        hit_stat = paddr_i == acsi_pkg::OFS_STATUS;
	wire        hit_mask = paddr_i == acsi_pkg::OFS_MASK;
	wire        hit_res  = paddr_i == acsi_pkg::OFS_RESULT;
	wire        hit_cfg  = paddr_i == acsi_pkg::OFS_CFG;
	wire        hit_st   = paddr_i == acsi_pkg::OFS_STATE;
	wire        mapped   = hit_ctrl || hit_stat || hit_mask || hit_res || hit_cfg || hit_st;
	wire        wr       = acc_end && pwrite_i && mapped;
	wire [2:0]  ev_set   = {read_last, cfg_last, conv_done};
	wire [2:0]  ev_clr   = (wr && hit_stat) ? pwdata_i[2:0] : 3'h0;
	// Set beats clear so no event is lost in the clearing cycle
	wire [2:0]  next_status = (status & ~ev_clr) | ev_set;
	wire [31:0] rd_data  =
		hit_ctrl ? {30'h0000_0000, ctrl} :
		hit_stat ? {29'h0000_0000, status} :
		hit_mask ? {29'h0000_0000, mask} :
		hit_res  ? {16'h0000, result} :
		hit_cfg  ? {16'h0000, cfg_word} :
		hit_st   ? {27'h000_0000, conv_busy, busy_ind, mode_chain, state} :
		32'h0000_0000;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end
		else
		begin
			pready_o  <= acc;
			pslverr_o <= acc && !mapped;
			prdata_o  <= (acc && !pwrite_i) ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl   <= acsi_pkg::CTRL_RESET;
			mask   <= acsi_pkg::MASK_RESET;
			status <= acsi_pkg::EV_RESET;
			irq_o  <= 1'b0;
		end
		else
		begin
			if (wr && hit_ctrl)
				ctrl <= pwdata_i[1:0];
			if (wr && hit_mask)
				mask <= pwdata_i[2:0];
			status <= next_status;
			irq_o  <= |(next_status & mask);
		end
	end

	mode_latch_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		conv_go |=> (mode_chain == !$past(pins.cfg_in)))
		else $error("Mode not latched from config input");
	conv_start_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		conv_go |=> (state == ACSI_CONV) ##21 (state == ACSI_READ))
		else $error("Convert edge did not run a conversion");
	cs_enable_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(state == ACSI_READ && !mode_chain && !pins.start) |=> serial_result_oe_o)
		else $error("Select mode output not enabled");
	chain_enable_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(mode_chain && !pins.start) |=> !serial_result_oe_o)
		else $error("Chain output driven with convert low");
	release_out_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(!mode_chain && pins.start && pins.cfg_in) |=> (!serial_result_oe_o && !serial_result_out_o))
		else $error("Output active while released");
	busy_flag_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(conv_done && !mode_chain && !pins.start) |=> busy_ind ##1 (serial_result_out_o || sck_fall))
		else $error("Busy indicator missing at completion");
	chain_shift_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(shift_now && mode_chain) |=> (shreg[0] == $past(chain_cap) && shreg[15] == $past(shreg[14])))
		else $error("Chain shift lost a bit");
	cfg_word_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		cfg_last |=> (cfg_word[0] == $past(pins.cfg_in) && cfg_cnt == 5'h00))
		else $error("Config word not stored after 16 bits");
	status_sticky_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		conv_done |=> status[acsi_pkg::EV_CONV_BIT] ##1 irq_o == |(status & mask))
		else $error("Event lost or interrupt wrong");
endmodule : acsi_core

// ---- verilog/acsi_pkg.sv ----
// Shared constants and carrier types for the converter serial interface.
// Assumes a 40 MHz core clock and an APB master with 32-bit data.
package acsi_pkg;
	localparam int          CLK_PERIOD_NS = 25;
	localparam int          CONV_TIME_NS  = 500;
	// Least time, so round up to whole cycles
	localparam int          CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WORD_BITS     = 16;
	localparam int          CHAIN_DELAY   = 16;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_MASK      = 8'h08;
	localparam logic [7:0]  OFS_RESULT    = 8'h0C;
	localparam logic [7:0]  OFS_CFG       = 8'h10;
	localparam logic [7:0]  OFS_STATE     = 8'h14;
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_CFG_BIT  = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h1;
	localparam int          EV_CONV_BIT   = 0;
	localparam int          EV_CFG_BIT    = 1;
	localparam int          EV_READ_BIT   = 2;
	localparam logic [2:0]  EV_RESET      = 3'h0;
	localparam logic [2:0]  MASK_RESET    = 3'h0;
	localparam logic [15:0] WORD_RESET    = 16'h0000;

	typedef struct packed {
		logic start;
		logic sck;
		logic cfg_in;
	} acsi_pins_t;

	typedef struct packed {
		logic [2:0] readout;
		logic [2:0] cfg;
		logic [2:0] conv;
	} acsi_unused_t;
endpackage : acsi_pkg

// ---- verilog/acsi_sync.sv ----
// Two-flop synchroniser for the pin inputs, one stage pair per bit.
// Assumes inputs are asynchronous levels from the pins.
`timescale 1ns/100ps
module acsi_sync
#(
	parameter int W = 3
)
(
	input  wire logic         core_clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			// First stage is read only by the second
			always_ff @(posedge core_clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					meta[g]   <= 1'b0;
					sync_o[g] <= 1'b0;
				end
				else
				begin
					meta[g]   <= async_i[g];
					sync_o[g] <= meta[g];
				end
			end
		end
	endgenerate
endmodule : acsi_sync
